// File: core/gpfc_top.sv
// Global function control for the general pins, low-power pin and LEDs.
//
// Function
// - Low register: eight pin fields, reset 00
// - High bits 15:14 select pins 12-14
// - High low byte: pins 8 to 11
// - Bit 13 low enables low-power pin drive
// - Bit 12 level driven onto low-power pin
// - Bit 11 reads low-power pin, read-only
// - LED bit one releases high, zero drives
// - Shared page keeps contents over soft reset
// - Enable bit drives pin under function code 11 only, input reports level
`default_nettype none
`timescale 1ns/1ps

module gpfc_top (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_sw_reset,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [14:0] i_pin_out_reg,
    input wire logic [14:0] i_pin_oe_reg,
    output logic [14:0] o_pin_in_level,
    input wire logic [14:0] i_gp_pin_in,
    output logic [14:0] o_gp_pin_out,
    output logic [14:0] o_gp_pin_oe,
    input wire logic i_lp_pin_in,
    output logic o_lp_pin_out,
    output logic o_lp_pin_oe,
    input wire logic [3:0] i_led_drive,
    output logic [3:0] o_led_out,
    output logic [3:0] o_led_oe
);

    // ======================================================================
    // Register access
    // ======================================================================
    logic [15:0] page_q;
    logic [15:0] fn_low_q;
    logic [15:0] fn_high_q;
    logic lp_meta_q;
    logic lp_level_q;
    logic on_general;
    logic wr_low;
    logic wr_high;
    logic [15:0] high_read;

    assign on_general = (page_q == gpfc_pkg::PAGE_GENERAL);
    assign wr_low = i_reg_wr && on_general &&
        (i_reg_addr == gpfc_pkg::ADDR_FN_LOW);
    assign wr_high = i_reg_wr && on_general &&
        (i_reg_addr == gpfc_pkg::ADDR_FN_HIGH);

    // A software reset with no page write in the same cycle returns only the page pointer to the main page; the
    // general page is shared by all ports and must survive it.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_q <= gpfc_pkg::PAGE_MAIN;
        end else if (i_reg_wr && i_reg_addr == gpfc_pkg::ADDR_PAGE) begin
            page_q <= i_reg_wdata;
        end else if (i_sw_reset) begin
            page_q <= gpfc_pkg::PAGE_MAIN;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fn_low_q <= gpfc_pkg::FN_LOW_RESET;
        end else if (wr_low) begin
            fn_low_q <= i_reg_wdata;
        end
    end

    // Bit 11 is a live pin view and bit 8 reads zero, so neither is stored.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fn_high_q <= gpfc_pkg::FN_HIGH_RESET;
        end else if (wr_high) begin
            fn_high_q <= i_reg_wdata & gpfc_pkg::FN_HIGH_WMASK;
        end
    end

    always_comb begin
        high_read = fn_high_q;
        high_read[gpfc_pkg::LP_IN_BIT] = lp_level_q;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 16'h0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (!i_reg_rd) begin
                o_reg_rdata <= 16'h0000;
            end else if (i_reg_addr == gpfc_pkg::ADDR_PAGE) begin
                o_reg_rdata <= page_q;
            end else if (on_general &&
                         i_reg_addr == gpfc_pkg::ADDR_FN_LOW) begin
                o_reg_rdata <= fn_low_q;
            end else if (on_general &&
                         i_reg_addr == gpfc_pkg::ADDR_FN_HIGH) begin
                o_reg_rdata <= high_read;
            end else begin
                o_reg_rdata <= 16'h0000;
            end
        end
    end

    // ======================================================================
    // General pins
    // ======================================================================
    genvar gi;
    generate
        for (gi = 0; gi < gpfc_pkg::PIN_COUNT; gi = gi + 1) begin : g_pin
            logic [1:0] sel;
            if (gi < gpfc_pkg::LOW_REG_PINS) begin : g_low
                assign sel = fn_low_q[gi*2 +: 2];
            end else if (gi < gpfc_pkg::LOW_REG_PINS +
                              gpfc_pkg::HIGH_REG_PINS) begin : g_mid
                assign sel =
                    fn_high_q[(gi - gpfc_pkg::LOW_REG_PINS)*2 +: 2];
            end else begin : g_grp
                assign sel = fn_high_q[gpfc_pkg::GROUP_LSB +: 2];
            end
            gpfc_pin_cell u_cell (
                .i_ref_clk(i_ref_clk),
                .i_rst_n(i_rst_n),
                .i_fn_sel(sel),
                .i_out_bit(i_pin_out_reg[gi]),
                .i_oe_bit(i_pin_oe_reg[gi]),
                .i_pin_in(i_gp_pin_in[gi]),
                .o_pin_out(o_gp_pin_out[gi]),
                .o_pin_oe(o_gp_pin_oe[gi]),
                .o_level(o_pin_in_level[gi])
            );
        end
    endgenerate

    // ======================================================================
    // Low-power hold pin
    // ======================================================================
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lp_meta_q <= 1'b0;
            lp_level_q <= 1'b0;
        end else begin
            lp_meta_q <= i_lp_pin_in;
            lp_level_q <= lp_meta_q;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_lp_pin_oe <= 1'b0;
            o_lp_pin_out <= 1'b0;
        end else begin
            o_lp_pin_oe <= ~fn_high_q[gpfc_pkg::LP_OE_N_BIT];
            o_lp_pin_out <= fn_high_q[gpfc_pkg::LP_OUT_BIT];
        end
    end

    // ======================================================================
    // LED drive mode
    // ======================================================================
    // Releasing instead of driving high lets an external pull-up lift the
    // LED lines above the I/O supply.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_led_oe <= 4'h0;
            o_led_out <= 4'h0;
        end else begin
            o_led_out <= i_led_drive;
            if (fn_high_q[gpfc_pkg::LED_TRI_BIT]) begin
                o_led_oe <= ~i_led_drive;
            end else begin
                o_led_oe <= 4'hF;
            end
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    low_field_write_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        wr_low |=> (fn_low_q == $past(i_reg_wdata)))
        else $error("low function register did not take the write");

    group_field_write_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        wr_high |=> (fn_high_q[15:14] == $past(i_reg_wdata[15:14]) &&
            fn_high_q[7:0] == $past(i_reg_wdata[7:0])))
        else $error("high function fields did not take the write");

    page_gate_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        (i_reg_wr && !on_general && i_reg_addr == gpfc_pkg::ADDR_FN_LOW)
        |=> $stable(fn_low_q))
        else $error("function register written off the general page");

    lp_oe_follow_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        wr_high |-> ##2 (o_lp_pin_oe ==
            !$past(i_reg_wdata[gpfc_pkg::LP_OE_N_BIT], 2)))
        else $error("low-power pin enable does not follow bit 13");

    lp_data_follow_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        wr_high |-> ##2 (o_lp_pin_out ==
            $past(i_reg_wdata[gpfc_pkg::LP_OUT_BIT], 2)))
        else $error("low-power pin data does not follow bit 12");

    lp_read_back_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        (i_reg_rd && on_general && i_reg_addr == gpfc_pkg::ADDR_FN_HIGH)
        |=> (o_reg_rvalid &&
            o_reg_rdata[gpfc_pkg::LP_IN_BIT] == $past(lp_level_q)))
        else $error("bit 11 does not show the low-power pin level");

    led_release_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        (fn_high_q[gpfc_pkg::LED_TRI_BIT] && i_led_drive[0])
        |=> !o_led_oe[0])
        else $error("LED driven high in release mode");

    led_drive_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        !fn_high_q[gpfc_pkg::LED_TRI_BIT] |=> (o_led_oe == 4'hF))
        else $error("LED not driven in push-pull mode");

    soft_reset_keep_a: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        (i_sw_reset && !i_reg_wr) |=>
        ($stable(fn_low_q) && $stable(fn_high_q)))
        else $error("software reset disturbed the general page");

endmodule // gpfc_top

`default_nettype wire

// File: inc/gpfc_pkg.sv
// Constants for the general pin function control block.
`default_nettype none

package gpfc_pkg;

    // ======================================================================
    // Register addresses and page selection
    // ======================================================================
    localparam logic [4:0] ADDR_FN_LOW = 5'h0D;
    localparam logic [4:0] ADDR_FN_HIGH = 5'h0E;
    localparam logic [4:0] ADDR_PAGE = 5'h1F;
    localparam logic [15:0] PAGE_GENERAL = 16'h0010;
    localparam logic [15:0] PAGE_MAIN = 16'h0000;

    // ======================================================================
    // Reset values and write masks
    // ======================================================================
    localparam logic [15:0] FN_LOW_RESET = 16'h0000;
    localparam logic [15:0] FN_HIGH_RESET = 16'h2400;
    localparam logic [15:0] FN_HIGH_WMASK = 16'hF6FF;

    // ======================================================================
    // Field layout
    // ======================================================================
    localparam int FN_WIDTH = 2;
    localparam logic [1:0] FN_REG_CTRL = 2'h3;
    localparam int PIN_COUNT = 15;
    localparam int LOW_REG_PINS = 8;
    localparam int HIGH_REG_PINS = 4;
    localparam int GROUP_LSB = 14;
    localparam int LP_OE_N_BIT = 13;
    localparam int LP_OUT_BIT = 12;
    localparam int LP_IN_BIT = 11;
    localparam int LED_TRI_BIT = 9;
    localparam int LED_COUNT = 4;

endpackage

`default_nettype wire

// File: core/gpfc_pin_cell.sv
// One general pin: function gating, output drive and input synchroniser.
`default_nettype none
`timescale 1ns/1ps

module gpfc_pin_cell (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_fn_sel,
    input wire logic i_out_bit,
    input wire logic i_oe_bit,
    input wire logic i_pin_in,
    output logic o_pin_out,
    output logic o_pin_oe,
    output logic o_level
);

    logic meta_q;
    logic reg_ctrl;

    assign reg_ctrl = (i_fn_sel == gpfc_pkg::FN_REG_CTRL);

    // Reserved function codes leave the pin released; nothing else may
    // drive it from this block.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin_oe <= 1'b0;
            o_pin_out <= 1'b0;
        end else begin
            o_pin_oe <= reg_ctrl & i_oe_bit;
            o_pin_out <= reg_ctrl & i_out_bit;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta_q <= i_pin_in;
            o_level <= meta_q;
        end
    end

    pin_drive_on_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (reg_ctrl && i_oe_bit) |=> (o_pin_oe && o_pin_out == $past(i_out_bit)))
        else $error("enabled pin under register control not driven");

    pin_reserved_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (!reg_ctrl) |=> (!o_pin_oe && !o_pin_out))
        else $error("pin driven under a reserved function code");

    pin_level_sync_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |-> ##2 (o_level == $past(i_pin_in, 2)))
        else $error("pin level not seen two cycles later");

endmodule // gpfc_pin_cell

`default_nettype wire

// File: dv/gpfc_mgmt_model.sv
// Station management controller model that drives the register port.
`timescale 1ns/1ps
`default_nettype none

module gpfc_mgmt_model (
    input wire logic i_ref_clk,
    output logic [4:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_wdata
);
    initial begin
        o_addr = 5'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 16'h0000;
    end

    // Released lines are inverted so stale values are never mistaken.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_ref_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask

    task automatic rd(input logic [4:0] a);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_ref_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
    endtask

    task automatic page(input logic on);
        wr(gpfc_pkg::ADDR_PAGE,
           on ? gpfc_pkg::PAGE_GENERAL : gpfc_pkg::PAGE_MAIN);
    endtask
endmodule // gpfc_mgmt_model

`default_nettype wire

// File: dv/general_pin_function_control_tb_top.sv
// Self-checking bench for the general pin function control block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module general_pin_function_control_tb_top;
    localparam logic [4:0] LO = gpfc_pkg::ADDR_FN_LOW;
    localparam logic [4:0] HI = gpfc_pkg::ADDR_FN_HIGH;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sw_rst = 1'b0;
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic [14:0] pout = 15'h0000;
    logic [14:0] poe = 15'h0000;
    logic [14:0] pin = 15'h0000;
    logic [14:0] lvl;
    logic [14:0] gout;
    logic [14:0] goe;
    logic lp_in = 1'b0;
    logic lp_out;
    logic lp_oe;
    logic [3:0] led = 4'h0;
    logic [3:0] led_out;
    logic [3:0] led_oe;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    int n_errors = 0;
    int checked = 0;

    always #5 clk = ~clk;

    gpfc_top dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_sw_reset(sw_rst),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_pin_out_reg(pout), .i_pin_oe_reg(poe), .o_pin_in_level(lvl),
        .i_gp_pin_in(pin), .o_gp_pin_out(gout), .o_gp_pin_oe(goe),
        .i_lp_pin_in(lp_in), .o_lp_pin_out(lp_out), .o_lp_pin_oe(lp_oe),
        .i_led_drive(led), .o_led_out(led_out), .o_led_oe(led_oe)
    );

    gpfc_mgmt_model u_mgmt (
        .i_ref_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata)
    );

    task automatic report_and_stop();
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic rd_exp(input logic [4:0] a, input logic [15:0] x);
        exp_q.push_back(x);
        u_mgmt.rd(a);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Read data is matched against the oldest expectation.
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
            `CHK(rdata, e)
        end
    end

    initial begin
        #100000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        logic [1:0] c;
        void'($urandom(13));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        `CHK(lp_oe, 1'b0)
        `CHK(led_oe, 4'hF)
        u_mgmt.wr(LO, 16'hFFFF);
        rd_exp(LO, 16'h0000);
        u_mgmt.page(1'b1);
        rd_exp(LO, 16'h0000);
        rd_exp(HI, 16'h2400);
        rd_exp(5'h05, 16'h0000);
        poe <= 15'h7FFF;
        pout <= 15'h7FFF;
        for (int k = 0; k < 8; k++) begin
            u_mgmt.wr(LO, 16'h0003 << (2 * k));
            settle(2);
            `CHK(goe, 15'h0001 << k)
            `CHK(gout, 15'h0001 << k)
        end
        for (int k = 0; k < 4; k++) begin
            // Only codes 00 and 11 are written; the others are reserved.
            c = {2{k[0]}};
            @(posedge clk);
            pout <= 15'($urandom);
            poe <= 15'($urandom);
            pin <= 15'($urandom);
            led <= 4'($urandom);
            lp_in <= 1'($urandom);
            u_mgmt.wr(LO, {8{c}});
            u_mgmt.wr(HI, {c, 1'b0, c[0], 2'b11, c[1], 1'b0, {4{c}}});
            settle(2);
            `CHK(goe, (c == 2'h3) ? poe : 15'h0000)
            `CHK(gout, (c == 2'h3) ? pout : 15'h0000)
            `CHK(lvl, pin)
            `CHK(lp_oe, 1'b1)
            `CHK(lp_out, c[0])
            `CHK(led_oe, c[1] ? ~led : 4'hF)
            `CHK(led_out, led)
            rd_exp(HI, {c, 1'b0, c[0], lp_in, 1'b1, c[1], 1'b0, {4{c}}});
            rd_exp(LO, {8{c}});
        end
        u_mgmt.wr(HI, 16'hE403);
        settle(2);
        `CHK(goe, {poe[14:12], 3'h0, poe[8:0]})
        `CHK(lp_oe, 1'b0)
        @(posedge clk);
        sw_rst <= 1'b1;
        @(posedge clk);
        sw_rst <= 1'b0;
        rd_exp(LO, 16'h0000);
        u_mgmt.page(1'b1);
        rd_exp(LO, 16'hFFFF);
        u_mgmt.page(1'b0);
        settle(3);
        `CHK(exp_q.size(), 0)
        report_and_stop();
    end
endmodule // general_pin_function_control_tb_top

`default_nettype wire
